/* File: common/mss_defs.vh */
/*
 * constants of the motor start sequencer: register byte offsets, field
 * positions, reset values, setting limits and the millisecond time base.
 * assumes inclusion by bare name from the core files; definitions only.
 */
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

// register byte offsets on the wishbone slave
`define MSS_REG_CTRL 8'h00
`define MSS_REG_CFG 8'h04
`define MSS_REG_FLIM 8'h08
`define MSS_REG_SCUR 8'h0c
`define MSS_REG_BRAKE 8'h10
`define MSS_REG_FMAX 8'h14
`define MSS_REG_FMIN 8'h18
`define MSS_REG_FCUR 8'h1c
`define MSS_REG_STAT 8'h20

// control register fields
`define MSS_CTRL_RUN 0
`define MSS_CTRL_COMM 1

// configuration register fields
`define MSS_CFG_NUM_LSB 0
`define MSS_CFG_MODE_LSB 16

// status register fields
`define MSS_STAT_PHASE_LSB 0
`define MSS_STAT_BRAKE 4
`define MSS_STAT_ACCEL 5
`define MSS_STAT_HOLD 6
`define MSS_STAT_FLUX 7
`define MSS_STAT_CURR 8
`define MSS_STAT_TIMER_LSB 16

// reset values
`define MSS_CFG_RST 10'h06e
`define MSS_MODE_RST 8'h00
`define MSS_FLIM_RST 14'h104
`define MSS_BRAKE_RST 16'h0000
`define MSS_RATED_CUR 16'h00fa
`define MSS_OVL_PCT 16'h0096

// setting limits in their own units (0.01 hz, ms)
`define MSS_FLIM_MAX 14'h2710
`define MSS_BRAKE_MIN 16'hec78
`define MSS_BRAKE_MAX 16'h1388
`define MSS_FTIME_MAX 14'h2710
`define MSS_FTIME_MIN 14'h0001

// flux-formation time defaults per configuration family, ms
`define MSS_FMAX_VF 14'h012c
`define MSS_FMAX_FOC 14'h03e8
`define MSS_FMAX_SYNC 14'h0032
`define MSS_FMIN_VF 14'h000a
`define MSS_FMIN_FOC 14'h0032
`define MSS_FMIN_SYNC 14'h0032

// time base: clock in khz, tick period in ms, cycles per tick
`define MSS_CLK_KHZ 25000
`define MSS_TICK_MS 1
`define MSS_TICK_CYCLES (`MSS_CLK_KHZ * `MSS_TICK_MS)

`endif

/* File: core/mss_ms_tick.v */
/*
 * millisecond time base: one-cycle tick every CYCLES enabled clocks.
 * assumes a synchronous active-high reset and a clock enable that
 * freezes the count; clr_i restarts the period.
 */
`timescale 1ns/1ps
`default_nettype none

module mss_ms_tick #(
    parameter CYCLES = 25000
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // restart and tick
    input wire clr_i,
    output reg tick_o
);

    reg [15:0] cnt_q;

    // divider down-counter, reloads on clear or on reaching zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (clr_i || cnt_q == 16'h0000) begin
                cnt_q <= CYCLES[15:0] - 16'h0001;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
            tick_o <= !clr_i && cnt_q == 16'h0001;
        end
    end

endmodule // mss_ms_tick

`default_nettype wire

/* File: core/mss_seq.v */
/*
 * motor start sequencer: brake release delay, flux formation, starting
 * current impression up to the frequency limit, then normal control.
 * assumes a classic wishbone master, a power stage giving output
 * frequency and flux-reached, and synchronous inputs on clk_i.
 */
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.vh"

module mss_seq #(
    parameter TICK_CYCLES = `MSS_TICK_CYCLES,
    parameter [15:0] RATED_CUR = `MSS_RATED_CUR,
    parameter [15:0] OVL_PCT = `MSS_OVL_PCT
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // power stage feedback
    input wire [13:0] output_freq_i,
    input wire flux_reached_i,
    input wire [13:0] commission_freq_i,
    // drive outputs
    output reg brake_release_o,
    output reg [2:0] phase_o,
    output reg accel_enable_o,
    output reg freq_hold_o,
    output reg flux_impress_o,
    output reg start_current_impress_o,
    output reg [15:0] start_current_o,
    output reg [15:0] flux_current_component_o
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_BRAKE = 3'h1;
    localparam [2:0] ST_FLUX = 3'h2;
    localparam [2:0] ST_CURR = 3'h3;
    localparam [2:0] ST_RUN = 3'h4;

    // byte-lane merge of a write into the current word
    function [31:0] wb_merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            wb_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    wb_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // unsigned clamp to an upper limit
    function [15:0] clamp_u;
        input [15:0] v;
        input [15:0] lim;
        begin
            clamp_u = (v > lim) ? lim : v;
        end
    endfunction

    // configuration family: hundreds digit of the configuration number, 9 for every number from 900 up
    function [3:0] cfg_family;
        input [9:0] num;
        begin
            cfg_family = 4'h0;
            if (num >= 10'h384) cfg_family = 4'h9;
            else if (num >= 10'h320) cfg_family = 4'h8;
            else if (num >= 10'h2bc) cfg_family = 4'h7;
            else if (num >= 10'h258) cfg_family = 4'h6;
            else if (num >= 10'h1f4) cfg_family = 4'h5;
            else if (num >= 10'h190) cfg_family = 4'h4;
            else if (num >= 10'h12c) cfg_family = 4'h3;
            else if (num >= 10'h0c8) cfg_family = 4'h2;
            else if (num >= 10'h064) cfg_family = 4'h1;
        end
    endfunction

    wire [31:0] scur_max_w = RATED_CUR * OVL_PCT;
    wire [31:0] scur_div_w = scur_max_w / 32'h00000064;
    wire [15:0] scur_lim = (scur_div_w > 32'h0000ffff) ? 16'hffff : scur_div_w[15:0];

    // registers
    reg run_q;
    reg run_prev_q;
    reg [9:0] cfg_q;
    reg [7:0] mode_q;
    reg [13:0] flim_q;
    reg [15:0] brake_q;
    reg [13:0] fmax_q;
    reg [13:0] fmin_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [13:0] ms_q;
    reg [13:0] brk_ms_q;
    reg [31:0] rd_val;
    reg [31:0] wr_val;

    wire tick;
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire start_pulse = run_q && !run_prev_q;

    // clamped write values, cut to the 14-bit register width where stored
    wire [15:0] flim_wr = clamp_u(wr_val[15:0], {2'b00, `MSS_FLIM_MAX});
    wire [15:0] comm_wr = clamp_u({2'b00, commission_freq_i}, {2'b00, `MSS_FLIM_MAX});
    wire [15:0] fmin_wr = clamp_u(wr_val[15:0], {2'b00, `MSS_FTIME_MAX});
    wire [15:0] fmax_wr = (fmin_wr < {2'b00, `MSS_FTIME_MIN}) ? {2'b00, `MSS_FTIME_MIN} : fmin_wr;

    // configuration decode
    wire [3:0] fam = cfg_family(cfg_q);
    wire is_vf = fam == 4'h1;
    wire is_foc = fam == 4'h2 || fam == 4'h4 || fam == 4'h6;
    wire vf_mag = is_vf && (mode_q == 8'h01 || mode_q == 8'h02 || mode_q == 8'h03
                  || mode_q == 8'h04 || mode_q == 8'h0c || mode_q == 8'h0e);
    wire need_flux = is_foc || vf_mag;
    wire need_curr = (is_vf && (mode_q == 8'h02 || mode_q == 8'h04
                     || mode_q == 8'h0c || mode_q == 8'h0e))
                     || fam == 4'h4 || cfg_q == 10'h262;

    // brake delay sign and magnitude
    wire brake_neg = brake_q[15];
    wire [15:0] brake_abs = brake_neg ? (16'h0000 - brake_q) : brake_q;
    wire [13:0] brake_mag = brake_abs[13:0];

    // flux-formation end: max always ends, min gates an early flux-reached except in v/f magnetizing, where flux-reached is ignored
    wire flux_max_hit = ms_q >= fmax_q;
    wire flux_min_ok = ms_q >= fmin_q;
    wire flux_done = vf_mag && !is_foc ? flux_max_hit
                   : (flux_max_hit || (flux_reached_i && flux_min_ok));

    mss_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clr_i(start_pulse),
        .tick_o(tick)
    );

    // register read mux
    always @* begin
        rd_val = 32'h00000000;
        case (wb_adr_i)
            `MSS_REG_CTRL: rd_val[`MSS_CTRL_RUN] = run_q;
            `MSS_REG_CFG: begin
                rd_val[`MSS_CFG_NUM_LSB +: 10] = cfg_q;
                rd_val[`MSS_CFG_MODE_LSB +: 8] = mode_q;
            end
            `MSS_REG_FLIM: rd_val[13:0] = flim_q;
            `MSS_REG_SCUR: rd_val[15:0] = start_current_o;
            `MSS_REG_BRAKE: rd_val[15:0] = brake_q;
            `MSS_REG_FMAX: rd_val[13:0] = fmax_q;
            `MSS_REG_FMIN: rd_val[13:0] = fmin_q;
            `MSS_REG_FCUR: rd_val[15:0] = flux_current_component_o;
            `MSS_REG_STAT: begin
                rd_val[`MSS_STAT_PHASE_LSB +: 3] = state_q;
                rd_val[`MSS_STAT_BRAKE] = brake_release_o;
                rd_val[`MSS_STAT_ACCEL] = accel_enable_o;
                rd_val[`MSS_STAT_HOLD] = freq_hold_o;
                rd_val[`MSS_STAT_FLUX] = flux_impress_o;
                rd_val[`MSS_STAT_CURR] = start_current_impress_o;
                rd_val[`MSS_STAT_TIMER_LSB +: 14] = ms_q;
            end
            default: rd_val = 32'h00000000;
        endcase
        wr_val = wb_merge(rd_val, wb_dat_i, wb_sel_i);
    end

    // wishbone answer: ack one cycle after the request, dropped after one
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_val : 32'h00000000;
        end
    end

    // register writes with range clamping, commissioning and config defaults
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            run_prev_q <= 1'b0;
            cfg_q <= `MSS_CFG_RST;
            mode_q <= `MSS_MODE_RST;
            flim_q <= `MSS_FLIM_RST;
            start_current_o <= RATED_CUR;
            brake_q <= `MSS_BRAKE_RST;
            fmax_q <= `MSS_FMAX_VF;
            fmin_q <= `MSS_FMIN_VF;
            flux_current_component_o <= RATED_CUR;
        end else if (ce_i) begin
            run_prev_q <= run_q;
            if (bus_wr) begin
                case (wb_adr_i)
                    `MSS_REG_CTRL: begin
                        run_q <= wr_val[`MSS_CTRL_RUN];
                        if (wr_val[`MSS_CTRL_COMM] && is_foc) begin
                            flim_q <= comm_wr[13:0];
                        end
                    end
                    `MSS_REG_CFG: begin
                        cfg_q <= wr_val[`MSS_CFG_NUM_LSB +: 10];
                        mode_q <= wr_val[`MSS_CFG_MODE_LSB +: 8];
                        case (cfg_family(wr_val[`MSS_CFG_NUM_LSB +: 10]))
                            4'h1: begin
                                fmax_q <= `MSS_FMAX_VF;
                                fmin_q <= `MSS_FMIN_VF;
                            end
                            4'h6: begin
                                fmax_q <= `MSS_FMAX_SYNC;
                                fmin_q <= `MSS_FMIN_SYNC;
                            end
                            default: begin
                                fmax_q <= `MSS_FMAX_FOC;
                                fmin_q <= `MSS_FMIN_FOC;
                            end
                        endcase
                    end
                    `MSS_REG_FLIM: begin
                        flim_q <= flim_wr[13:0];
                    end
                    `MSS_REG_SCUR: start_current_o <= clamp_u(wr_val[15:0], scur_lim);
                    `MSS_REG_BRAKE: begin
                        if ($signed(wr_val[15:0]) < $signed(`MSS_BRAKE_MIN)) begin
                            brake_q <= `MSS_BRAKE_MIN;
                        end else if ($signed(wr_val[15:0]) > $signed(`MSS_BRAKE_MAX)) begin
                            brake_q <= `MSS_BRAKE_MAX;
                        end else begin
                            brake_q <= wr_val[15:0];
                        end
                    end
                    `MSS_REG_FMAX: begin
                        fmax_q <= fmax_wr[13:0];
                    end
                    `MSS_REG_FMIN: begin
                        fmin_q <= fmin_wr[13:0];
                    end
                    `MSS_REG_FCUR: flux_current_component_o <= clamp_u(wr_val[15:0], scur_lim);
                    default: run_q <= run_q;
                endcase
            end
        end
    end

    // phase sequencing: brake delay, flux, starting current, control
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_pulse) state_d = ST_BRAKE;
            end
            ST_BRAKE: begin
                if (brake_neg || ms_q >= brake_mag) begin
                    if (need_flux) state_d = ST_FLUX;
                    else if (need_curr) state_d = ST_CURR;
                    else state_d = ST_RUN;
                end
            end
            ST_FLUX: begin
                if (flux_done) state_d = need_curr ? ST_CURR : ST_RUN;
            end
            ST_CURR: begin
                if (output_freq_i > flim_q) state_d = ST_RUN;
            end
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
        if (!run_q) state_d = ST_IDLE;
    end

    // phase state, timers and registered drive outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            ms_q <= 14'h0000;
            brk_ms_q <= 14'h0000;
            phase_o <= ST_IDLE;
            brake_release_o <= 1'b0;
            accel_enable_o <= 1'b0;
            freq_hold_o <= 1'b0;
            flux_impress_o <= 1'b0;
            start_current_impress_o <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            phase_o <= state_d;
            // phase timer restarts on every phase entry and on a new start, zero while idle
            if (start_pulse || state_d != state_q || state_q == ST_IDLE) begin
                ms_q <= 14'h0000;
            end else if (tick && ms_q != 14'h3fff) begin
                ms_q <= ms_q + 14'h0001;
            end
            // brake timer runs from the start command across phases
            if (start_pulse) begin
                brk_ms_q <= 14'h0000;
            end else if (tick && brk_ms_q != 14'h3fff) begin
                brk_ms_q <= brk_ms_q + 14'h0001;
            end
            brake_release_o <= state_d != ST_IDLE
                               && (!brake_neg || brk_ms_q >= brake_mag);
            accel_enable_o <= state_d == ST_CURR || state_d == ST_RUN;
            freq_hold_o <= state_d == ST_BRAKE || state_d == ST_FLUX;
            flux_impress_o <= state_d == ST_FLUX;
            start_current_impress_o <= state_d == ST_CURR;
        end
    end

endmodule // mss_seq

`default_nettype wire

/* File: bench/mss_seq_asserts.sv */
/* checker for mss_seq: phase order, output coupling, bus timing.
   assumes binding to mss_seq with ce_i held high. */
`timescale 1ns/1ps
`default_nettype none
module mss_seq_chk #(
    parameter [15:0] RATED_CUR = 16'h00fa,
    parameter [15:0] OVL_PCT = 16'h0096
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // drive side
    input wire logic [13:0] output_freq_i,
    input wire logic [2:0] phase_o,
    input wire logic accel_enable_o,
    input wire logic freq_hold_o,
    input wire logic flux_impress_o,
    input wire logic start_current_impress_o,
    input wire logic [15:0] start_current_o
);
    localparam [31:0] IMAX = RATED_CUR * OVL_PCT / 32'h64;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // motor must not accelerate before brake delay and flux end
    a_accel_gated: assert property (
        (phase_o == 3'h1 || phase_o == 3'h2) |-> !accel_enable_o)
        else $error("acceleration during delay or flux");
    a_flux_hold: assert property (
        phase_o == 3'h2 |-> freq_hold_o && flux_impress_o && !start_current_impress_o)
        else $error("flux phase outputs wrong");
    a_curr_phase: assert property (
        start_current_impress_o == (phase_o == 3'h3))
        else $error("starting current outside its phase");
    a_no_handover: assert property (
        phase_o == 3'h3 && output_freq_i == 14'h0 |=> phase_o != 3'h4)
        else $error("handover at zero frequency");
    a_phase_order: assert property (
        $changed(phase_o) && phase_o != 3'h0 |-> phase_o > $past(phase_o))
        else $error("phase went backwards");
    a_accel_source: assert property (
        $rose(accel_enable_o) |-> $past(phase_o) == 3'h1 || $past(phase_o) == 3'h2)
        else $error("acceleration not after delay or flux");
    a_cur_limit: assert property (
        start_current_o <= IMAX[15:0])
        else $error("starting current above limit");
    // single-cycle answer on the bus, data zero otherwise
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
endmodule // mss_seq_chk
bind mss_seq mss_seq_chk #(.RATED_CUR(RATED_CUR), .OVL_PCT(OVL_PCT)) mss_seq_chk_inst (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .output_freq_i,
    .phase_o, .accel_enable_o, .freq_hold_o, .flux_impress_o, .start_current_impress_o,
    .start_current_o);
`default_nettype wire

/* File: bench/mss_motor_model.sv */
/* motor model: flux builds while flux current flows, shaft speeds up
   while acceleration is allowed and the brake is open.
   assumes drive outputs of mss_seq on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module mss_motor_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // drive commands
    input wire logic flux_impress_i,
    input wire logic accel_i,
    input wire logic brake_release_i,
    input wire logic [15:0] flux_delay_i,
    // feedback
    output logic [13:0] output_freq_o,
    output logic flux_reached_o
);
    logic [15:0] flux_q;
    // magnetizing current reaches rating after flux_delay_i cycles
    always @(posedge clk_i) begin
        if (rst_i || !flux_impress_i) flux_q <= 16'h0;
        else if (flux_q < flux_delay_i) flux_q <= flux_q + 16'h1;
    end
    assign flux_reached_o = flux_impress_i && flux_q >= flux_delay_i;
    // a held brake keeps the shaft still
    always @(posedge clk_i) begin
        if (rst_i || !accel_i) output_freq_o <= 14'h0;
        else if (brake_release_i) output_freq_o <= output_freq_o + 14'h1;
    end
endmodule // mss_motor_model
`default_nettype wire

/* File: bench/tb_top.sv */
/* self-checking bench for mss_seq: registers over wishbone and start
   sequences against the motor model. assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int T = 10;
    logic clk_i, rst_i, ce_i, cyc, stb, we, ack, fok, brk, acc, hold, fimp, cimp;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, rd;
    logic [13:0] freq, comm;
    logic [2:0] phase;
    logic [15:0] fdel, scur, fcur;
    int modes[4] = '{2, 4, 12, 14};
    int n_fail, check_count, bcyc, cnt[5];
    int tf[5][5] = '{'{2, 9, 40, 38, 53}, '{6, 9, 10, 48, 63}, '{0, 9, 10, 8, 23},
                     '{5, 5, 16'hffff, 38, 53}, '{8, 4, 10, 28, 43}};
    mss_seq #(.TICK_CYCLES(T)) mss_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .output_freq_i(freq),
        .flux_reached_i(fok), .commission_freq_i(comm), .brake_release_o(brk),
        .phase_o(phase), .accel_enable_o(acc), .freq_hold_o(hold),
        .flux_impress_o(fimp), .start_current_impress_o(cimp), .start_current_o(scur),
        .flux_current_component_o(fcur));
    mss_motor_model mss_motor_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .flux_impress_i(fimp), .accel_i(acc), .brake_release_i(brk),
        .flux_delay_i(fdel), .output_freq_o(freq), .flux_reached_o(fok));
    // 25 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo, input int hi, input string m);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: %s %0d not in %0d..%0d", $time, m, got, lo, hi);
        end
    endtask
    // one classic cycle; request held until ack is sampled
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            finish_test;
        end
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input string m);
        wb(a, 1'b0, 32'h0);
        chk(rd, e, m);
    endtask
    // program, start, count cycles per phase until handover, stop
    task run(input logic [31:0] cfg, br, fmax, fmin, input logic [15:0] fd);
        int n;
        fdel <= fd;
        wb(8'h04, 1'b1, cfg); wb(8'h10, 1'b1, br);
        wb(8'h14, 1'b1, fmax); wb(8'h18, 1'b1, fmin);
        wb(8'h00, 1'b1, 32'h1);
        cnt = '{default: 0}; bcyc = -1; n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (phase < 3'h5) cnt[phase]++;
            if (brk === 1'b1 && bcyc < 0) bcyc = n;
        end while (phase !== 3'h4 && n < 3000);
        chk(phase, 32'h4, "handover");
        if (phase !== 3'h4) finish_test;
        wb(8'h00, 1'b1, 32'h0);
        $display("run cfg %h done", cfg);
    endtask
    initial begin
        rst_i = 1'b1; ce_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0;
        sel = 4'hf; dat = 32'h0; comm = 14'h1f4; fdel = 16'h0;
        n_fail = 0; check_count = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(8'h04, 32'h6e, "cfg"); rc(8'h08, 32'h104, "flim");
        rc(8'h0c, 32'hfa, "scur"); rc(8'h10, 32'h0, "brake");
        rc(8'h14, 32'h12c, "fmax"); rc(8'h18, 32'ha, "fmin");
        wb(8'h20, 1'b1, 32'hffff); rc(8'h20, 32'h0, "stat");
        wb(8'h24, 1'b1, 32'h1); rc(8'h24, 32'h0, "unmapped");
        wb(8'h08, 1'b1, 32'h3fff); rc(8'h08, 32'h2710, "flim max");
        wb(8'h0c, 1'b1, 32'hffff); rc(8'h0c, 32'h177, "scur max");
        chk(scur, 32'h177, "scur pin");
        rc(8'h1c, 32'hfa, "fcur");
        wb(8'h1c, 1'b1, 32'hffff); rc(8'h1c, 32'h177, "fcur max");
        chk(fcur, 32'h177, "fcur pin");
        wb(8'h10, 1'b1, 32'hec00); rc(8'h10, 32'hec78, "brake min");
        wb(8'h10, 1'b1, 32'h1400); rc(8'h10, 32'h1388, "brake max");
        wb(8'h14, 1'b1, 32'h0); rc(8'h14, 32'h1, "fmax min");
        wb(8'h18, 1'b1, 32'h3fff); rc(8'h18, 32'h2710, "fmin max");
        wb(8'h04, 1'b1, 32'h19a); rc(8'h14, 32'h3e8, "fmax foc");
        wb(8'h04, 1'b1, 32'h262); rc(8'h14, 32'h32, "fmax sync");
        wb(8'h04, 1'b1, 32'h6e); wb(8'h08, 1'b1, 32'h104); wb(8'h00, 1'b1, 32'h2);
        rc(8'h08, 32'h104, "comm vf");
        wb(8'h04, 1'b1, 32'h19a); wb(8'h00, 1'b1, 32'h2);
        rc(8'h08, 32'h1f4, "comm foc");
        $display("register test done");
        wb(8'h08, 1'b1, 32'h14);
        run(32'h1006e, 32'h2, 32'h4, 32'h1, 16'h0);
        chk_rng(cnt[1], 2 * T - 2, 2 * T + 3, "brake delay");
        chk_rng(bcyc, 0, 3, "brake open");
        chk_rng(cnt[2], 3 * T - 2, 4 * T + 3, "mode 1 hold");
        chk(cnt[3], 32'h0, "mode 1 current");
        foreach (tf[i]) begin
            run(32'h19a, 32'h0, tf[i][1], tf[i][0], tf[i][2][15:0]);
            chk_rng(cnt[2], tf[i][3], tf[i][4], "flux time");
        end
        foreach (modes[i]) begin
            run(32'h6e | (modes[i] << 16), 32'h0, 32'h3, 32'h1, 16'h0);
            chk_rng(cnt[3], 21, 25, "start current");
        end
        run(32'h262, 32'h0, 32'h3, 32'h1, 16'h0);
        chk_rng(cnt[3], 21, 25, "sync current");
        run(32'h0d2, 32'h0, 32'h3, 32'h1, 16'h0);
        chk(cnt[3], 32'h0, "2xx current");
        run(32'h19a, 32'hfffd, 32'h3, 32'h1, 16'h0);
        chk_rng(cnt[1], 0, 3, "negative delay");
        chk_rng(bcyc, 3 * T - 2, 3 * T + 3, "late brake");
        // clock enable low freezes the brake delay phase
        wb(8'h04, 1'b1, 32'h6e); wb(8'h10, 1'b1, 32'h3); wb(8'h00, 1'b1, 32'h1);
        ce_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(phase, 32'h1, "ce freeze");
        ce_i <= 1'b1;
        wb(8'h00, 1'b1, 32'h0);
        $display("ce test done");
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
